//--- verilog/timer8_pkg.sv
// shared constants and types of the 8-bit timer/counter
package timer8_pkg;

  // --------------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFF_COUNT  = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_CH0CTL = 8'h08;
  localparam logic [7:0] OFF_CH0VAL = 8'h0C;
  localparam logic [7:0] OFF_CH1CTL = 8'h10;
  localparam logic [7:0] OFF_CH1VAL = 8'h14;
  localparam logic [7:0] OFF_FLAGS  = 8'h18;
  localparam logic [7:0] OFF_CLKCTL = 8'h1C;
  localparam logic [7:0] OFF_MASK   = 8'h20;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int CTRL_DIV_LSB   = 5;
  localparam int CTRL_START_BIT = 4;
  localparam int CTRL_MASK_BIT  = 3;
  localparam int CTRL_CLR_BIT   = 2;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CH_IM_BIT      = 6;
  localparam int CH_CMP_LSB     = 3;
  localparam int CH_SEL_BIT     = 2;
  localparam int CH_EDGE_LSB    = 0;
  localparam int FLAG_TC_BIT    = 0;
  localparam int FLAG_CH0_BIT   = 1;
  localparam int FLAG_CH1_BIT   = 2;
  localparam int NUM_CH         = 2;

  // --------------------------------------------------------------------------
  // reset values and counter constants
  // --------------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST   = 8'h08;
  localparam logic [7:0] CHCTL_RST  = 8'h40;
  localparam logic [7:0] CHVAL_RST  = 8'h00;
  localparam logic [2:0] CLKCTL_RST = 3'h0;
  localparam logic [7:0] CNT_ZERO   = 8'h00;
  localparam logic [7:0] CNT_TOP    = 8'hFF;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  localparam int         PRE_W      = 14;

  // --------------------------------------------------------------------------
  // encodings
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FREE   = 2'h0,
    MODE_DOWN   = 2'h1,
    MODE_MODULO = 2'h2,
    MODE_UPDOWN = 2'h3
  } count_mode_t;

  localparam logic [2:0] CMP_SET    = 3'h0;
  localparam logic [2:0] CMP_CLEAR  = 3'h1;
  localparam logic [2:0] CMP_TOGGLE = 3'h2;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL  = 2'h2;
  localparam logic [1:0] EDGE_ANY   = 2'h3;

endpackage : timer8_pkg

//--- verilog/tick_prescaler.sv
// active clock edge generator: tick speed then power-of-two divider
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
  import timer8_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // divider selects
  input  wire logic [2:0] tickSel,
  input  wire logic [2:0] divSel,
  // one-cycle active edge
  output logic            tickEn
);

  logic [PRE_W-1:0] preCnt_ff;
  logic [3:0]       shiftAmt;
  logic [PRE_W-1:0] lowMask;

  // combined divisor is 2^(tick+div)
  assign shiftAmt = {1'b0, tickSel} + {1'b0, divSel};
  assign lowMask  = ({{(PRE_W-1){1'b0}}, 1'b1} << shiftAmt)
                    - {{(PRE_W-1){1'b0}}, 1'b1};
  assign tickEn   = (preCnt_ff & lowMask) == lowMask;

  // free-running prescale counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      preCnt_ff <= '0;
    else
      preCnt_ff <= preCnt_ff + {{(PRE_W-1){1'b0}}, 1'b1};
  end

endmodule : tick_prescaler
`default_nettype wire

//--- verilog/timer_channel.sv
// one capture/compare channel: edge detect and compare output pin
`timescale 1ns/1ps
`default_nettype none
module timer_channel
  import timer8_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // timer state
  input  wire logic       running,
  input  wire logic       tickEn,
  input  wire logic [7:0] count,
  input  wire logic [7:0] compareVal,
  // channel setup
  input  wire logic       isCompare,
  input  wire logic [1:0] edgeSel,
  input  wire logic [2:0] cmpMode,
  // synchronised pin level
  input  wire logic       pinSync,
  // events and pin drive
  output logic            captureEvt,
  output logic            compareEvt,
  output logic            pinOut_ff,
  output logic            pinOe_ff
);

  logic pinPrev_ff;
  logic riseSeen;
  logic fallSeen;
  logic edgeHit;
  logic nxt_pinOut;

  // edge selection for capture
  assign riseSeen   = pinSync & ~pinPrev_ff;
  assign fallSeen   = ~pinSync & pinPrev_ff;
  assign edgeHit    = (edgeSel == EDGE_RISE && riseSeen)
                   || (edgeSel == EDGE_FALL && fallSeen)
                   || (edgeSel == EDGE_ANY && (riseSeen || fallSeen));
  assign captureEvt = running & ~isCompare & edgeHit;
  assign compareEvt = running & isCompare & tickEn
                    & (count == compareVal);

  // output action on compare
  assign nxt_pinOut = (cmpMode == CMP_SET)    ? 1'b1 :
                      (cmpMode == CMP_CLEAR)  ? 1'b0 :
                      (cmpMode == CMP_TOGGLE) ? ~pinOut_ff : pinOut_ff;

  // pin history and drive
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinPrev_ff <= 1'b0;
      pinOut_ff  <= 1'b0;
      pinOe_ff   <= 1'b0;
    end
    else
    begin
      pinPrev_ff <= pinSync;
      pinOe_ff   <= isCompare;
      if (compareEvt)
        pinOut_ff <= nxt_pinOut;
    end
  end

endmodule : timer_channel
`default_nettype wire

//--- verilog/timer8_top.sv
// 8-bit timer/counter with two capture/compare channels on APB
// ----------------------------------------------------------------------------
// Notes on behaviour
// - eight-bit counter steps one per active edge
// - active edge is tick divided by prescaler
// - count register reads present counter value
// - start bit runs counter, zero holds it
// - free mode wraps 0xFF to 0x00, flags
// - down mode loads compare, flags at zero
// - flag and mask set raise interrupt
// - modulo mode resets at compare value, flags
// - up/down runs zero to compare and back
// - clear forces zero and upward direction
// - each channel selects capture or compare
// - capture on rising, falling or either edge
// - compare sets, clears or toggles output
// - channel and terminal events request interrupts
// - three-bit divider gives powers of two
// - two-bit mode field selects counting mode
// ----------------------------------------------------------------------------
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer8_top
  import timer8_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // channel pins
  input  wire logic [NUM_CH-1:0] chPinIn,
  output logic [NUM_CH-1:0]      chPinOut,
  output logic [NUM_CH-1:0]      chPinOe,
  // interrupt
  output logic                   timerIrq
);

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  // address match on one word
  function automatic logic regHit(input logic [7:0] addr,
                                  input logic [7:0] off);
    regHit = (addr == off);
  endfunction : regHit

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic              rstSync1_ff;
  logic              rstSync2_ff;
  logic              rst_n;
  logic [NUM_CH-1:0] pinMeta_ff;
  logic [NUM_CH-1:0] pinSync_ff;

  logic [2:0]        div_ff;
  logic              start_ff;
  logic              tcMask_ff;
  count_mode_t       mode_ff;
  logic [2:0]        tickSpeed_ff;
  logic [7:0]        chCtl_ff [NUM_CH];
  logic [7:0]        chVal_ff [NUM_CH];
  logic [2:0]        flags_ff;
  logic [7:0]        cnt_ff;
  logic              dirDown_ff;

  logic              pready_ff;
  logic [31:0]       prdata_ff;
  logic              pslverr_ff;
  logic              irq_ff;

  logic              setupPh;
  logic              wrDone;
  logic              mapped;
  logic              wrCtrl;
  logic              wrFlags;
  logic              wrClk;
  logic              wrMask;
  logic              clearReq;
  logic              startReq;
  logic              startRise;
  logic [7:0]        ctrlView;
  logic [2:0]        maskView;
  logic [31:0]       readMux;

  logic              tickEn;
  logic              stepNow;
  logic [7:0]        topVal;
  logic [7:0]        nxt_cnt;
  logic              nxt_dirDown;
  logic              tcHit;
  logic [NUM_CH-1:0] capEvt;
  logic [NUM_CH-1:0] cmpEvt;
  logic [NUM_CH-1:0] wrChCtl;
  logic [NUM_CH-1:0] wrChVal;
  logic [2:0]        flagSet;
  logic [2:0]        flagClr;

  // --------------------------------------------------------------------------
  // reset release and pin synchronisers
  // --------------------------------------------------------------------------
  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end
    else
    begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end
  assign rst_n = rstSync2_ff;

  // two flip-flops on each channel input
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end
    else
    begin
      pinMeta_ff <= chPinIn;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  // setup samples read data, access edge commits writes
  assign setupPh  = psel & ~penable;
  assign wrDone   = psel & penable & pready_ff & pwrite;
  assign mapped   = regHit(paddr, OFF_COUNT) | regHit(paddr, OFF_CTRL)
                  | regHit(paddr, OFF_CH0CTL) | regHit(paddr, OFF_CH0VAL)
                  | regHit(paddr, OFF_CH1CTL) | regHit(paddr, OFF_CH1VAL)
                  | regHit(paddr, OFF_FLAGS) | regHit(paddr, OFF_CLKCTL)
                  | regHit(paddr, OFF_MASK);
  assign wrCtrl   = wrDone & regHit(paddr, OFF_CTRL);
  assign wrFlags  = wrDone & regHit(paddr, OFF_FLAGS);
  assign wrClk    = wrDone & regHit(paddr, OFF_CLKCTL);
  assign wrMask   = wrDone & regHit(paddr, OFF_MASK);
  assign wrChCtl  = {wrDone & regHit(paddr, OFF_CH1CTL),
                     wrDone & regHit(paddr, OFF_CH0CTL)};
  assign wrChVal  = {wrDone & regHit(paddr, OFF_CH1VAL),
                     wrDone & regHit(paddr, OFF_CH0VAL)};

  // control side effects of a control write
  assign clearReq  = wrCtrl & pwdata[CTRL_CLR_BIT];
  assign startReq  = pwdata[CTRL_START_BIT];
  assign startRise = wrCtrl & startReq & ~start_ff;

  // read views; clear bit always reads zero
  assign ctrlView = {div_ff, start_ff, tcMask_ff, 1'b0, mode_ff};
  assign maskView = {chCtl_ff[1][CH_IM_BIT], chCtl_ff[0][CH_IM_BIT],
                     tcMask_ff};
  assign readMux  =
      regHit(paddr, OFF_COUNT)  ? {24'h000000, cnt_ff} :
      regHit(paddr, OFF_CTRL)   ? {24'h000000, ctrlView} :
      regHit(paddr, OFF_CH0CTL) ? {24'h000000, chCtl_ff[0]} :
      regHit(paddr, OFF_CH0VAL) ? {24'h000000, chVal_ff[0]} :
      regHit(paddr, OFF_CH1CTL) ? {24'h000000, chCtl_ff[1]} :
      regHit(paddr, OFF_CH1VAL) ? {24'h000000, chVal_ff[1]} :
      regHit(paddr, OFF_FLAGS)  ? {29'h00000000, flags_ff} :
      regHit(paddr, OFF_CLKCTL) ? {29'h00000000, tickSpeed_ff} :
      regHit(paddr, OFF_MASK)   ? {29'h00000000, maskView} :
                                  32'h00000000;

  // apb answer: no wait state, error on unmapped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setupPh;
      pslverr_ff <= setupPh & ~mapped;
      if (setupPh)
        prdata_ff <= pwrite ? 32'h00000000 : readMux;
    end
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  // timer control and tick speed
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_ff       <= CTRL_RST[CTRL_DIV_LSB +: 3];
      start_ff     <= CTRL_RST[CTRL_START_BIT];
      tcMask_ff    <= CTRL_RST[CTRL_MASK_BIT];
      mode_ff      <= count_mode_t'(CTRL_RST[CTRL_MODE_LSB +: 2]);
      tickSpeed_ff <= CLKCTL_RST;
    end
    else
    begin
      if (wrCtrl)
      begin
        div_ff    <= pwdata[CTRL_DIV_LSB +: 3];
        start_ff  <= startReq;
        tcMask_ff <= pwdata[CTRL_MASK_BIT];
        mode_ff   <= count_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
      end
      else if (wrMask)
        tcMask_ff <= pwdata[FLAG_TC_BIT];
      if (wrClk)
        tickSpeed_ff <= pwdata[2:0];
    end
  end

  // per-channel control and value registers
  generate
    for (genvar gi = 0; gi < NUM_CH; gi++)
    begin : g_chreg
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          chCtl_ff[gi] <= CHCTL_RST;
          chVal_ff[gi] <= CHVAL_RST;
        end
        else
        begin
          if (wrChCtl[gi])
            chCtl_ff[gi] <= {1'b0, pwdata[6:0]};
          else if (wrMask)
            chCtl_ff[gi][CH_IM_BIT] <= pwdata[FLAG_CH0_BIT + gi];
          if (capEvt[gi])
            chVal_ff[gi] <= cnt_ff;
          else if (wrChVal[gi])
            chVal_ff[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // prescaler and channels
  // --------------------------------------------------------------------------
  tick_prescaler u_pre (
    .clk     (clk),
    .rst_n   (rst_n),
    .tickSel (tickSpeed_ff),
    .divSel  (div_ff),
    .tickEn  (tickEn)
  );

  generate
    for (genvar gc = 0; gc < NUM_CH; gc++)
    begin : g_ch
      timer_channel u_ch (
        .clk        (clk),
        .rst_n      (rst_n),
        .running    (start_ff),
        .tickEn     (tickEn),
        .count      (cnt_ff),
        .compareVal (chVal_ff[gc]),
        .isCompare  (chCtl_ff[gc][CH_SEL_BIT]),
        .edgeSel    (chCtl_ff[gc][CH_EDGE_LSB +: 2]),
        .cmpMode    (chCtl_ff[gc][CH_CMP_LSB +: 3]),
        .pinSync    (pinSync_ff[gc]),
        .captureEvt (capEvt[gc]),
        .compareEvt (cmpEvt[gc]),
        .pinOut_ff  (chPinOut[gc]),
        .pinOe_ff   (chPinOe[gc])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // main counter
  // --------------------------------------------------------------------------
  // channel 0 value bounds the non-free modes
  assign topVal  = chVal_ff[0];
  assign stepNow = start_ff & tickEn;

  // next count, direction and terminal event per mode
  always_comb
  begin
    nxt_cnt     = cnt_ff;
    nxt_dirDown = dirDown_ff;
    tcHit       = 1'b0;
    unique case (mode_ff)
      MODE_FREE:
      begin
        nxt_cnt = cnt_ff + CNT_ONE;
        tcHit   = (cnt_ff == CNT_TOP);
      end
      MODE_DOWN:
      begin
        if (cnt_ff != CNT_ZERO)
          nxt_cnt = cnt_ff - CNT_ONE;
        tcHit = (cnt_ff == CNT_ONE);
      end
      MODE_MODULO:
      begin
        if (cnt_ff >= topVal)
        begin
          nxt_cnt = CNT_ZERO;
          tcHit   = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + CNT_ONE;
      end
      MODE_UPDOWN:
      begin
        if (!dirDown_ff)
        begin
          if (cnt_ff >= topVal)
          begin
            nxt_dirDown = 1'b1;
            nxt_cnt     = (cnt_ff == CNT_ZERO) ? CNT_ZERO
                                               : cnt_ff - CNT_ONE;
          end
          else
            nxt_cnt = cnt_ff + CNT_ONE;
        end
        else if (cnt_ff <= CNT_ONE)
        begin
          nxt_cnt     = CNT_ZERO;
          nxt_dirDown = 1'b0;
          tcHit       = 1'b1;
        end
        else
          nxt_cnt = cnt_ff - CNT_ONE;
      end
    endcase
  end

  // count register: clear beats load beats step
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff     <= CNT_ZERO;
      dirDown_ff <= 1'b0;
    end
    else if (clearReq)
    begin
      cnt_ff     <= CNT_ZERO;
      dirDown_ff <= 1'b0;
    end
    else if (startRise && pwdata[CTRL_MODE_LSB +: 2] == MODE_DOWN)
      cnt_ff <= topVal;
    else if (stepNow)
    begin
      cnt_ff     <= nxt_cnt;
      dirDown_ff <= nxt_dirDown;
    end
  end

  // --------------------------------------------------------------------------
  // flags and interrupt
  // --------------------------------------------------------------------------
  // sticky flags, write one clears, new event wins
  assign flagSet = {capEvt[1] | cmpEvt[1], capEvt[0] | cmpEvt[0],
                    stepNow & tcHit & ~clearReq};
  assign flagClr = wrFlags ? pwdata[2:0] : 3'h0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_ff <= 3'h0;
      irq_ff   <= 1'b0;
    end
    else
    begin
      flags_ff <= (flags_ff & ~flagClr) | flagSet;
      irq_ff   <= |(flags_ff & maskView);
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign pready   = pready_ff;
  assign prdata   = prdata_ff;
  assign pslverr  = pslverr_ff;
  assign timerIrq = irq_ff;

endmodule : timer8_top
`default_nettype wire

//--- test/timer8_assertions.sv
// port-level assertions for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module timer8_assertions
  import timer8_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              arst_n,
  // apb slave
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // pins and interrupt
  input wire logic [NUM_CH-1:0] chPinIn,
  input wire logic [NUM_CH-1:0] chPinOut,
  input wire logic [NUM_CH-1:0] chPinOe,
  input wire logic              timerIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // --------------------------------------------------------------------------
  // bus steps
  // --------------------------------------------------------------------------
  sequence setupAt;
    psel && !penable;
  endsequence
  sequence wrDone(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  answer_one_cycle_a: assert property (
    setupAt |=> pready ##1 !pready)
    else $error("pready not one access cycle");
  idle_no_ready_a: assert property (!psel |-> !pready)
    else $error("pready without select");
  unmapped_error_a: assert property (
    setupAt ##0 paddr > OFF_MASK |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    setupAt ##0 paddr <= OFF_MASK && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  flag_width_a: assert property (
    setupAt ##0 paddr == OFF_FLAGS |=> prdata[31:3] == 29'h0)
    else $error("flag read too wide");
  mask_off_irq_a: assert property (
    wrDone(OFF_MASK) ##0 pwdata[2:0] == 3'h0 |=> ##1 !timerIrq)
    else $error("interrupt despite all masks off");
  compare_drive_a: assert property (
    wrDone(OFF_CH1CTL) ##0 pwdata[CH_SEL_BIT] |=> ##[0:2] chPinOe[1])
    else $error("compare channel not driving");
  capture_input_a: assert property (
    wrDone(OFF_CH0CTL) ##0 !pwdata[CH_SEL_BIT] |=> ##[0:2] !chPinOe[0])
    else $error("capture channel still driving");
endmodule : timer8_assertions
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the 8-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb
  import timer8_pkg::*;
;
  logic        clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [1:0]  chPinIn;
  logic [1:0]  chPinOut;
  logic [1:0]  chPinOe;
  logic        timerIrq;
  logic [31:0] rd;
  int          n_fail;
  int          comparisons;

  timer8_top dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .chPinIn(chPinIn), .chPinOut(chPinOut), .chPinOe(chPinOe),
    .timerIrq(timerIrq));

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask : idle

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = pslverr ? 32'hFFFFFFFF : prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    rdchk(OFF_COUNT, 32'h0);
    rdchk(OFF_CTRL, 32'h08);
    rdchk(OFF_CH0CTL, 32'h40);
    rdchk(OFF_CH1CTL, 32'h40);
    rdchk(OFF_CLKCTL, 32'h0);
    rdchk(8'h40, 32'hFFFFFFFF);
    $display("done: reset");
  endtask : t_reset

  task automatic t_free;
    logic [7:0] c0;
    apb(1'b1, OFF_CTRL, 32'h1C);
    apb(1'b0, OFF_COUNT, 32'h0);
    c0 = rd[7:0];
    apb(1'b0, OFF_COUNT, 32'h0);
    check(8'(rd[7:0] - c0), 32'h3);
    apb(1'b1, OFF_FLAGS, 32'h7);
    idle(260);
    apb(1'b0, OFF_FLAGS, 32'h0);
    check(rd[0], 1'b1);
    check(timerIrq, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h08);
    apb(1'b0, OFF_COUNT, 32'h0);
    c0 = rd[7:0];
    idle(20);
    rdchk(OFF_COUNT, c0);
    $display("done: free");
  endtask : t_free

  // count steps over 128 clocks for every divider code
  task automatic t_div;
    logic [7:0] c0;
    for (int d = 0; d < 9; d++)
    begin
      apb(1'b1, OFF_CLKCTL, (d == 8) ? 32'h1 : 32'h0);
      apb(1'b1, OFF_CTRL, {24'h0, 3'((d == 8) ? 1 : d), 5'h18});
      apb(1'b0, OFF_COUNT, 32'h0);
      c0 = rd[7:0];
      idle(125);
      apb(1'b0, OFF_COUNT, 32'h0);
      check(8'(rd[7:0] - c0), 128 >> ((d == 8) ? 2 : d));
    end
    apb(1'b1, OFF_CLKCTL, 32'h0);
    $display("done: divider");
  endtask : t_div

  task automatic t_down;
    apb(1'b1, OFF_CTRL, 32'h09);
    apb(1'b1, OFF_CH0VAL, 32'h06);
    apb(1'b1, OFF_FLAGS, 32'h7);
    apb(1'b1, OFF_CTRL, 32'h19);
    apb(1'b0, OFF_COUNT, 32'h0);
    check(rd > 0 && rd < 7, 1'b1);
    idle(20);
    rdchk(OFF_COUNT, 32'h0);
    apb(1'b0, OFF_FLAGS, 32'h0);
    check(rd[0], 1'b1);
    $display("done: down");
  endtask : t_down

  // reads five clocks apart visit every phase of the period
  task automatic t_cycle(input logic [31:0] run, input logic [7:0] nxt);
    logic [7:0] prev;
    logic [7:0] mx;
    mx = 8'h00;
    prev = 8'hFF;
    apb(1'b1, OFF_CTRL, run & 32'hEF | 32'h04);
    apb(1'b1, OFF_FLAGS, 32'h7);
    apb(1'b1, OFF_CTRL, run);
    repeat (14)
    begin
      apb(1'b0, OFF_COUNT, 32'h0);
      if (prev == 8'h06) check(rd, nxt);
      prev = rd[7:0];
      mx = (rd[7:0] > mx) ? rd[7:0] : mx;
      idle(2);
    end
    check(mx, 8'h06);
    apb(1'b0, OFF_FLAGS, 32'h0);
    check(rd[0], 1'b1);
    $display("done: mode %0d", run[1:0]);
  endtask : t_cycle

  // reads five clocks apart find the peak; clear then lands while falling
  task automatic t_clear;
    do
    begin
      idle(2);
      apb(1'b0, OFF_COUNT, 32'h0);
    end
    while (rd !== 32'h6);
    apb(1'b1, OFF_CTRL, 32'h1F);
    rdchk(OFF_COUNT, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h0F);
    rdchk(OFF_COUNT, 32'h0);
    $display("done: clear");
  endtask : t_clear

  task automatic t_irq;
    idle(1);
    check(timerIrq, 1'b1);
    apb(1'b1, OFF_MASK, 32'h0);
    idle(1);
    check(timerIrq, 1'b0);
    apb(1'b1, OFF_MASK, 32'h1);
    idle(1);
    check(timerIrq, 1'b1);
    apb(1'b1, OFF_FLAGS, 32'h1);
    idle(1);
    check(timerIrq, 1'b0);
    rdchk(OFF_FLAGS, 32'h0);
    $display("done: irq");
  endtask : t_irq

  task automatic t_chan;
    logic o;
    apb(1'b1, OFF_CH1VAL, 32'h10);
    apb(1'b1, OFF_CH1CTL, 32'h44);
    idle(4);
    check(chPinOe, 2'h2);
    apb(1'b1, OFF_CTRL, 32'h1C);
    idle(40);
    check(chPinOut[1], 1'b1);
    apb(1'b0, OFF_FLAGS, 32'h0);
    check(rd[2], 1'b1);
    check(timerIrq, 1'b1);
    apb(1'b1, OFF_CH1CTL, 32'h4C);
    idle(260);
    check(chPinOut[1], 1'b0);
    apb(1'b1, OFF_CH1CTL, 32'h54);
    idle(260);
    o = chPinOut[1];
    idle(256);
    check(chPinOut[1], !o);
    for (int e = 1; e < 4; e++)
    begin
      apb(1'b1, OFF_CH0CTL, 32'h40 | e);
      apb(1'b1, OFF_FLAGS, 32'h7);
      chPinIn[0] <= 1'b1;
      idle(8);
      apb(1'b0, OFF_FLAGS, 32'h0);
      check(rd[1], e[0]);
      apb(1'b1, OFF_FLAGS, 32'h7);
      chPinIn[0] <= 1'b0;
      idle(8);
      apb(1'b0, OFF_FLAGS, 32'h0);
      check(rd[1], e[1]);
    end
    apb(1'b1, OFF_CTRL, 32'h08);
    $display("done: channels");
  endtask : t_chan

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------------------
  // clock, sequence and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    n_fail = 0;
    comparisons = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chPinIn = 2'h0;
    idle(10);
    arst_n <= 1'b1;
    idle(4);
    t_reset;
    t_free;
    t_div;
    t_down;
    t_cycle(32'h1A, 8'h04);
    t_cycle(32'h1B, 8'h01);
    t_clear;
    t_irq;
    t_chan;
    report_and_stop;
  end

  initial
  begin
    idle(20000);
    n_fail++;
    report_and_stop;
  end
endmodule : tb

bind timer8_top timer8_assertions chk_u (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .chPinIn(chPinIn), .chPinOut(chPinOut), .chPinOe(chPinOe),
  .timerIrq(timerIrq));
`default_nettype wire
